// *** inc/adc_seq_pkg.sv ***
// Shared constants, types and helpers of the converter sequencer.
`default_nettype none
package adc_seq_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_FREQ_MHZ = 100;
  localparam int CONV_TIME_NS = 400;
  localparam int MAX_RES_BITS = 12;
  localparam int CONV12_CYCLES = (CONV_TIME_NS * CLK_FREQ_MHZ) / 1000;
  localparam int BIT_MIN_CYCLES = (CONV12_CYCLES / MAX_RES_BITS) < 1 ? 1 : CONV12_CYCLES / MAX_RES_BITS;
  localparam int CORE_STARTUP_NS = 1000;
  localparam int STARTUP_CYCLES = (CORE_STARTUP_NS * CLK_FREQ_MHZ + 999) / 1000;

  // ---------------------------------------------------------------
  // Channels
  // ---------------------------------------------------------------
  localparam int NUM_CHAN = 19;
  localparam int NUM_EXT = 10;
  localparam logic [4:0] CH_TEMP = 5'h0A;
  localparam logic [4:0] CH_BANDGAP = 5'h0B;
  localparam logic [4:0] CH_CORE_SUPPLY = 5'h0C;
  localparam logic [4:0] CH_LAST_USED = CH_CORE_SUPPLY;
  localparam logic [NUM_CHAN-1:0] CHAN_USED_MASK = 19'h01FFF;

  // ---------------------------------------------------------------
  // Resolution, flags and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] RES_12 = 2'h0;
  localparam logic [1:0] RES_10 = 2'h1;
  localparam logic [1:0] RES_8 = 2'h2;
  localparam logic [1:0] RES_6 = 2'h3;
  localparam int OVS_ACC_W = 20;
  localparam int FLAG_W = 7;
  localparam int FLG_EOSMP = 0;
  localparam int FLG_EOC = 1;
  localparam int FLG_EOS = 2;
  localparam int FLG_AWD0 = 3;
  localparam int FLG_OVR = 6;
  localparam logic [15:0] DATA_RST = 16'h0000;

  typedef enum logic [1:0] {TRIG_OFF, TRIG_RISE, TRIG_FALL, TRIG_BOTH} trig_pol_t;

  function automatic logic [4:0] res_bits(input logic [1:0] sel);
    return 5'(12 - 2 * int'(sel));
  endfunction

  // Lowest set channel at or above 'from'; bit 5 of the result says one was found.
  function automatic logic [5:0] next_chan(input logic [NUM_CHAN-1:0] m, input logic [5:0] from);
    logic [5:0] r;
    r = 6'h00;
    for (int i = NUM_CHAN - 1; i >= 0; i--) begin
      if (m[i] && i >= int'(from)) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction
endpackage
`default_nettype wire

// *** inc/wdg_if.sv ***
// Connection between the sequencer and its threshold watchdogs.
`default_nettype none
interface wdg_if;
  logic check;
  logic [11:0] value;
  logic [2:0][11:0] high;
  logic [2:0][11:0] low;
  logic [2:0] hit;
  modport seq (output check, output value, output high, output low, input hit);
  modport cmp (input check, input value, input high, input low, output hit);
endinterface
`default_nettype wire

// *** src/range_watchdog.sv ***
// Three independent window comparators on the converted value at each result write.
`default_nettype none
module range_watchdog (
  input wire logic clk,
  input wire logic rst_n,
  wdg_if.cmp w
);
  // ---------------------------------------------------------------
  // Comparison
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      w.hit <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        w.hit[i] <= w.check && (w.value > w.high[i] || w.value < w.low[i]);
      end
    end
  end

  above_high_a: assert property (@(posedge clk) disable iff (!rst_n)
    w.check && w.value > w.high[2] |=> w.hit[2])
    else $error("watchdog 2 missed a value above its upper threshold");
  inside_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    !w.check |=> w.hit == 3'h0)
    else $error("watchdog flagged without a conversion");
endmodule
`default_nettype wire

// *** src/sar_converter_unit.sv ***
// Sequencer and successive approximation control of the 12-bit converter.
`default_nettype none
module sar_converter_unit
  import adc_seq_pkg::*;
#(
  parameter int NUM_TRIG = 4,
  parameter int SMP_W = 8,
  parameter int DIV_W = 8
) (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic ENABLE,
  input wire logic [1:0] RES_SEL,
  input wire logic ALIGN_LEFT,
  input wire logic CONT_EN,
  input wire logic SCAN_EN,
  input wire logic DISC_EN,
  input wire logic [4:0] CHAN_SEL,
  input wire logic [NUM_CHAN-1:0] SEQ_MASK,
  input wire logic SW_START,
  input wire logic SW_STOP,
  input wire logic [$clog2(NUM_TRIG)-1:0] TRIG_SEL,
  input wire logic [NUM_TRIG-1:0] TRIG_IN,
  input wire trig_pol_t TRIG_POL,
  input wire logic OVS_EN,
  input wire logic [2:0] OVS_RATIO,
  input wire logic [3:0] OVS_SHIFT,
  input wire logic WAIT_EN,
  input wire logic AUTO_OFF_EN,
  input wire logic AUTONOMOUS_EN,
  input wire logic DMA_EN,
  input wire logic [DIV_W-1:0] CLK_DIV,
  input wire logic [SMP_W-1:0] SMP_TICKS,
  input wire logic [2:0][11:0] AWD_HIGH,
  input wire logic [2:0][11:0] AWD_LOW,
  input wire logic DATA_READ,
  input wire logic [FLAG_W-1:0] FLAG_CLR,
  input wire logic [FLAG_W-1:0] FLAG_IE,
  input wire logic COMP_IN,
  output logic CORE_POWER,
  output logic CORE_SAMPLE,
  output logic [4:0] CORE_CHANNEL,
  output logic [11:0] CORE_DAC,
  output logic [15:0] DATA,
  output logic DATA_VALID,
  output logic DMA_REQ,
  output logic [FLAG_W-1:0] FLAGS,
  output logic WAKEUP_REQ,
  output logic BUSY
);
  // Parameter values that the logic cannot serve stop elaboration.
  if (NUM_TRIG < 2 || SMP_W < 1 || DIV_W < 2) begin : g_bad_params
    $error("sar_converter_unit: unsupported parameter values");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_PREP, ST_SAMPLE, ST_CONVERT, ST_STORE} seq_state_t;

  seq_state_t st_r;
  logic [DIV_W-1:0] div_cnt_r;
  logic tick_r;
  logic trig_prev_r;
  logic stop_r;
  logic resume_r;
  logic [$clog2(STARTUP_CYCLES+1)-1:0] pwr_cnt_r;
  logic [SMP_W-1:0] smp_cnt_r;
  logic [3:0] bit_idx_r;
  logic [7:0] ovs_cnt_r;
  logic [OVS_ACC_W-1:0] acc_r;
  logic [4:0] conv_len_r;
  logic [FLAG_W-1:0] flag_set;
  wdg_if wd ();

  // ---------------------------------------------------------------
  // Converter clock enable
  // ---------------------------------------------------------------
  // The divider never ticks more often than every BIT_MIN_CYCLES clocks, the bit time of a 0.4 us 12-bit conversion rounded down.
  logic [DIV_W-1:0] div_lim;
  assign div_lim = (CLK_DIV < DIV_W'(BIT_MIN_CYCLES - 1)) ? DIV_W'(BIT_MIN_CYCLES - 1) : CLK_DIV;

  always_ff @(posedge REF_CLK) begin
    if (!RESETN || st_r == ST_IDLE) begin
      div_cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (div_cnt_r == div_lim);
      div_cnt_r <= (div_cnt_r == div_lim) ? '0 : div_cnt_r + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Start sources and channel selection
  // ---------------------------------------------------------------
  logic trig_now;
  logic hw_edge;
  logic start_req;
  logic start_ok;
  logic [NUM_CHAN-1:0] chan_mask;
  logic [5:0] first_ch;
  logic [5:0] after_ch;
  logic [4:0] lsb;
  logic [11:0] raw_right;
  logic last_ovs;
  logic data_wr;

  assign trig_now = TRIG_IN[TRIG_SEL];
  assign hw_edge = (TRIG_POL == TRIG_RISE && trig_now && !trig_prev_r)
                || (TRIG_POL == TRIG_FALL && !trig_now && trig_prev_r)
                || (TRIG_POL == TRIG_BOTH && trig_now != trig_prev_r);
  assign start_req = SW_START || hw_edge;
  // Reserved codes never reach the multiplexer; an empty selection ignores starts.
  assign chan_mask = (SCAN_EN ? SEQ_MASK : NUM_CHAN'(1) << CHAN_SEL) & CHAN_USED_MASK;
  assign first_ch = next_chan(chan_mask, 6'h00);
  assign after_ch = next_chan(chan_mask, 6'(CORE_CHANNEL) + 6'h01);
  assign start_ok = start_req && first_ch[5] && (ENABLE || AUTO_OFF_EN || AUTONOMOUS_EN);
  assign lsb = 5'(MAX_RES_BITS) - res_bits(RES_SEL);
  assign raw_right = CORE_DAC >> lsb;
  // The exponent is widened first, so a ratio of 256 does not wrap to a shift of zero.
  assign last_ovs = !OVS_EN || ovs_cnt_r == 8'((9'h001 << ({1'b0, OVS_RATIO} + 4'h1)) - 9'h001);
  assign data_wr = st_r == ST_STORE && last_ovs;

  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      // Tracking the pin through reset avoids a false edge when it idles high.
      trig_prev_r <= trig_now;
    end else begin
      trig_prev_r <= trig_now;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      st_r <= ST_IDLE;
      CORE_CHANNEL <= 5'h00;
      resume_r <= 1'b0;
      smp_cnt_r <= '0;
      bit_idx_r <= 4'h0;
      CORE_DAC <= 12'h000;
      conv_len_r <= 5'h00;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
          if (start_ok) begin
            st_r <= ST_PREP;
            if (!(DISC_EN && resume_r && chan_mask[CORE_CHANNEL])) begin
              CORE_CHANNEL <= first_ch[4:0];
            end
          end
        end
        ST_PREP: begin
          // Wait mode holds here while the last result is unread.
          if (pwr_cnt_r == '0 && !(WAIT_EN && DATA_VALID) && tick_r) begin
            st_r <= ST_SAMPLE;
            smp_cnt_r <= '0;
          end
        end
        ST_SAMPLE: begin
          if (tick_r) begin
            smp_cnt_r <= smp_cnt_r + 1'b1;
            if (smp_cnt_r == SMP_TICKS) begin
              st_r <= ST_CONVERT;
              bit_idx_r <= 4'hB;
              CORE_DAC <= 12'h800;
              conv_len_r <= 5'h00;
            end
          end
        end
        ST_CONVERT: begin
          if (tick_r) begin
            conv_len_r <= conv_len_r + 5'h01;
            CORE_DAC[bit_idx_r] <= COMP_IN;
            if (5'(bit_idx_r) == lsb) begin
              st_r <= ST_STORE;
            end else begin
              bit_idx_r <= bit_idx_r - 4'h1;
              CORE_DAC[bit_idx_r - 4'h1] <= 1'b1;
            end
          end
        end
        ST_STORE: begin
          if (!last_ovs) begin
            st_r <= ST_PREP;
          end else if (SCAN_EN && after_ch[5]) begin
            CORE_CHANNEL <= after_ch[4:0];
            resume_r <= DISC_EN;
            st_r <= (DISC_EN || stop_r) ? ST_IDLE : ST_PREP;
          end else begin
            resume_r <= 1'b0;
            CORE_CHANNEL <= first_ch[4:0];
            st_r <= (CONT_EN && !DISC_EN && !stop_r) ? ST_PREP : ST_IDLE;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Core power
  // ---------------------------------------------------------------
  // Auto-off and autonomous use trade start-up latency on every start for core power.
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      CORE_POWER <= 1'b0;
      pwr_cnt_r <= '0;
    end else begin
      if (st_r == ST_IDLE && start_ok && !CORE_POWER) begin
        CORE_POWER <= 1'b1;
        pwr_cnt_r <= ($bits(pwr_cnt_r))'(STARTUP_CYCLES);
      end else if (st_r == ST_IDLE && !start_ok) begin
        CORE_POWER <= ENABLE && !AUTO_OFF_EN && !AUTONOMOUS_EN;
        pwr_cnt_r <= CORE_POWER ? pwr_cnt_r : ($bits(pwr_cnt_r))'(STARTUP_CYCLES);
      end else if (pwr_cnt_r != '0) begin
        pwr_cnt_r <= pwr_cnt_r - 1'b1;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      CORE_SAMPLE <= 1'b0;
      BUSY <= 1'b0;
      stop_r <= 1'b0;
    end else begin
      CORE_SAMPLE <= (st_r == ST_PREP && pwr_cnt_r == '0 && !(WAIT_EN && DATA_VALID) && tick_r)
                  || (st_r == ST_SAMPLE && !(tick_r && smp_cnt_r == SMP_TICKS));
      BUSY <= st_r != ST_IDLE;
      stop_r <= (st_r != ST_IDLE) && (stop_r || SW_STOP);
    end
  end

  // ---------------------------------------------------------------
  // Oversampling and result register
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RESETN || st_r == ST_IDLE) begin
      acc_r <= '0;
      ovs_cnt_r <= 8'h00;
    end else if (st_r == ST_STORE) begin
      acc_r <= last_ovs ? '0 : acc_r + OVS_ACC_W'(raw_right);
      ovs_cnt_r <= last_ovs ? 8'h00 : ovs_cnt_r + 8'h01;
    end
  end

  // The whole word is loaded in one edge, so no read sees half of two results.
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      DATA <= DATA_RST;
      DATA_VALID <= 1'b0;
      DMA_REQ <= 1'b0;
    end else begin
      if (data_wr) begin
        if (OVS_EN) begin
          DATA <= 16'((acc_r + OVS_ACC_W'(raw_right)) >> OVS_SHIFT);
        end else begin
          DATA <= ALIGN_LEFT ? 16'(raw_right) << (5'h10 - res_bits(RES_SEL)) : 16'(raw_right);
        end
      end
      DATA_VALID <= data_wr || (DATA_VALID && !DATA_READ);
      DMA_REQ <= DMA_EN && (data_wr || (DATA_VALID && !DATA_READ));
    end
  end

  // ---------------------------------------------------------------
  // Watchdogs and event flags
  // ---------------------------------------------------------------
  assign wd.check = data_wr;
  assign wd.value = CORE_DAC;
  assign wd.high = AWD_HIGH;
  assign wd.low = AWD_LOW;

  range_watchdog u_wdg (
    .clk(REF_CLK),
    .rst_n(RESETN),
    .w(wd)
  );

  always_comb begin
    flag_set = '0;
    flag_set[FLG_EOSMP] = st_r == ST_SAMPLE && tick_r && smp_cnt_r == SMP_TICKS;
    flag_set[FLG_EOC] = data_wr;
    flag_set[FLG_EOS] = data_wr && !(SCAN_EN && after_ch[5]);
    flag_set[FLG_AWD0 +: 3] = wd.hit;
    flag_set[FLG_OVR] = data_wr && DATA_VALID && !DATA_READ;
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      FLAGS <= '0;
      WAKEUP_REQ <= 1'b0;
    end else begin
      FLAGS <= flag_set | (FLAGS & ~FLAG_CLR);
      WAKEUP_REQ <= |((flag_set | (FLAGS & ~FLAG_CLR)) & FLAG_IE);
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);

  sequence sample_done_s;
    st_r == ST_SAMPLE ##1 st_r == ST_CONVERT;
  endsequence
  sequence idle_quiet_s;
    (st_r == ST_IDLE && !start_ok && (AUTO_OFF_EN || AUTONOMOUS_EN)) [*2];
  endsequence

  conv_length_a: assert property (st_r == ST_CONVERT ##1 st_r == ST_STORE |-> conv_len_r == res_bits(RES_SEL))
    else $error("conversion took the wrong number of bit steps");
  channel_legal_a: assert property (CORE_SAMPLE |-> CORE_CHANNEL <= CH_LAST_USED)
    else $error("reserved channel reached the multiplexer");
  left_align_a: assert property (data_wr && ALIGN_LEFT && !OVS_EN && RES_SEL == RES_8 |=> DATA[7:0] == 8'h00)
    else $error("left-aligned 8-bit result has low bits set");
  data_stable_a: assert property (!data_wr |=> $stable(DATA))
    else $error("result changed outside a result write");
  single_stop_a: assert property (data_wr && !CONT_EN && !SCAN_EN |=> st_r == ST_IDLE)
    else $error("single conversion did not stop");
  cont_repeat_a: assert property (data_wr && CONT_EN && !SCAN_EN && !DISC_EN && !stop_r |=> st_r == ST_PREP)
    else $error("continuous mode did not restart");
  start_take_a: assert property (st_r == ST_IDLE && start_ok |=> st_r == ST_PREP ##1 st_r != ST_IDLE)
    else $error("accepted start did not begin a conversion");
  eosmp_flag_a: assert property (sample_done_s |-> FLAGS[FLG_EOSMP])
    else $error("end of sampling not flagged");
  wait_hold_a: assert property (st_r == ST_PREP && WAIT_EN && DATA_VALID |=> st_r == ST_PREP)
    else $error("wait mode started over an unread result");
  auto_off_a: assert property (idle_quiet_s |-> !CORE_POWER)
    else $error("core left powered while idle in auto-off");
  disc_step_a: assert property (data_wr && SCAN_EN && DISC_EN && after_ch[5] |=> st_r == ST_IDLE && resume_r)
    else $error("discontinuous mode ran past one channel");
  overrun_a: assert property (data_wr && DATA_VALID && !DATA_READ |=> FLAGS[FLG_OVR] && DATA_VALID)
    else $error("overwrite of unread result not flagged");
endmodule
`default_nettype wire

// *** verif/analog_core_model.sv ***
// Behavioural analog multiplexer and converter core facing the sequencer.
`default_nettype none
module analog_core_model
  import adc_seq_pkg::*;
(
  input wire logic clk,
  input wire logic power,
  input wire logic sample,
  input wire logic [4:0] channel,
  input wire logic [11:0] dac,
  input wire logic [NUM_CHAN-1:0][11:0] levels,
  output logic comp_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] held_r = 12'h000;
  logic wander_r = 1'b0;
  // The hold capacitor keeps the level present when the sample switch opens.
  always_ff @(posedge clk) begin
    wander_r <= ~wander_r;
    if (sample) begin
      held_r <= levels[channel];
    end
  end
  // An unpowered comparator gives no usable answer, so it wanders every cycle.
  assign comp_in = power ? (held_r >= dac) : wander_r;
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench of the converter sequencer with a behavioural core.
`default_nettype none
module tb_top
  import adc_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic REF_CLK = 1'b0;
  logic RESETN = 1'b0;
  logic ENABLE, ALIGN_LEFT, CONT_EN, SCAN_EN, DISC_EN, SW_START, SW_STOP, OVS_EN;
  logic WAIT_EN, AUTO_OFF_EN, AUTONOMOUS_EN, DMA_EN, DATA_READ, COMP_IN;
  logic [1:0] RES_SEL, TRIG_SEL;
  logic [4:0] CHAN_SEL;
  logic [NUM_CHAN-1:0] SEQ_MASK;
  logic [3:0] TRIG_IN, OVS_SHIFT;
  trig_pol_t TRIG_POL;
  logic [2:0] OVS_RATIO;
  logic [7:0] CLK_DIV, SMP_TICKS;
  logic [2:0][11:0] AWD_HIGH, AWD_LOW;
  logic [FLAG_W-1:0] FLAG_CLR, FLAG_IE, FLAGS;
  logic CORE_POWER, CORE_SAMPLE, DATA_VALID, DMA_REQ, WAKEUP_REQ, BUSY;
  logic [4:0] CORE_CHANNEL;
  logic [11:0] CORE_DAC;
  logic [15:0] DATA;
  logic [NUM_CHAN-1:0][11:0] lvl;
  logic [4:0] chs [8];
  logic [4:0] sq [3];
  integer seed;
  int fails = 0;
  int samples_checked = 0;

  sar_converter_unit i_sar_converter_unit (.REF_CLK, .RESETN, .ENABLE, .RES_SEL, .ALIGN_LEFT, .CONT_EN,
    .SCAN_EN, .DISC_EN, .CHAN_SEL, .SEQ_MASK, .SW_START, .SW_STOP, .TRIG_SEL, .TRIG_IN, .TRIG_POL,
    .OVS_EN, .OVS_RATIO, .OVS_SHIFT, .WAIT_EN, .AUTO_OFF_EN, .AUTONOMOUS_EN, .DMA_EN, .CLK_DIV,
    .SMP_TICKS, .AWD_HIGH, .AWD_LOW, .DATA_READ, .FLAG_CLR, .FLAG_IE, .COMP_IN, .CORE_POWER,
    .CORE_SAMPLE, .CORE_CHANNEL, .CORE_DAC, .DATA, .DATA_VALID, .DMA_REQ, .FLAGS, .WAKEUP_REQ, .BUSY);
  analog_core_model i_analog_core_model (.clk(REF_CLK), .power(CORE_POWER), .sample(CORE_SAMPLE),
    .channel(CORE_CHANNEL), .dac(CORE_DAC), .levels(lvl), .comp_in(COMP_IN));

  always #5 REF_CLK = ~REF_CLK;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Lower resolutions keep the top bits of the full code.
  function automatic logic [15:0] fmt(input logic [11:0] code, input logic [1:0] rs, input logic left);
    int nb;
    logic [15:0] v;
    nb = 12 - 2 * int'(rs);
    v = 16'(code >> (12 - nb));
    return left ? 16'(v << (16 - nb)) : v;
  endfunction

  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic start();
    @(posedge REF_CLK);
    SW_START <= 1'b1;
    @(posedge REF_CLK);
    SW_START <= 1'b0;
  endtask

  task automatic wait_eoc(input int lim);
    int n;
    n = 0;
    do begin
      @(negedge REF_CLK);
      n++;
    end while (FLAGS[FLG_EOC] !== 1'b1 && n < lim);
    check("end of conversion", 16'(FLAGS[FLG_EOC]), 16'h1);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      @(negedge REF_CLK);
      n++;
    end while (BUSY !== 1'b0 && n < 3000);
    check("idle", 16'(BUSY), 16'h0);
  endtask

  task automatic clr(input logic rd);
    @(posedge REF_CLK);
    DATA_READ <= rd;
    FLAG_CLR <= '1;
    @(posedge REF_CLK);
    DATA_READ <= 1'b0;
    FLAG_CLR <= '0;
  endtask

  task automatic conv(input string what, input logic [15:0] exp, input int lim);
    start();
    wait_eoc(lim);
    repeat (2) @(negedge REF_CLK);
    check(what, DATA, exp);
  endtask

  // A wrong edge must leave the sequencer idle unless both edges are active.
  task automatic trig_test(input trig_pol_t pol, input logic lv);
    @(posedge REF_CLK);
    TRIG_POL <= TRIG_OFF;
    TRIG_IN[1] <= lv;
    repeat (3) @(posedge REF_CLK);
    TRIG_POL <= pol;
    repeat (3) @(posedge REF_CLK);
    TRIG_IN[1] <= ~lv;
    repeat (8) @(negedge REF_CLK);
    check("trigger edge", 16'(BUSY), 16'(pol == TRIG_BOTH));
    @(posedge REF_CLK);
    TRIG_IN[1] <= lv;
    wait_eoc(3000);
    check("trigger data", DATA, fmt(lvl[3], RES_12, 1'b0));
    wait_idle();
    clr(1'b1);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    seed = 32'h6c0e6e28;
    for (int i = 0; i < NUM_CHAN; i++) begin
      lvl[i] = 12'($random(seed));
    end
    lvl[4] = 12'h800;
    chs = '{5'h00, 5'h09, CH_TEMP, CH_BANDGAP, CH_CORE_SUPPLY, 5'h00, 5'h00, 5'h00};
    for (int i = 5; i < 8; i++) begin
      chs[i] = 5'($unsigned($random(seed)) % 13);
    end
    sq = '{5'h02, 5'h05, CH_TEMP};
    ENABLE = 1'b1;
    RES_SEL = RES_12;
    ALIGN_LEFT = 1'b0;
    CONT_EN = 1'b0;
    SCAN_EN = 1'b0;
    DISC_EN = 1'b0;
    CHAN_SEL = 5'h03;
    SEQ_MASK = 19'h08424;
    SW_START = 1'b0;
    SW_STOP = 1'b0;
    TRIG_SEL = 2'h1;
    TRIG_IN = 4'h0;
    TRIG_POL = TRIG_OFF;
    OVS_EN = 1'b0;
    OVS_RATIO = 3'h0;
    OVS_SHIFT = 4'h0;
    WAIT_EN = 1'b0;
    AUTO_OFF_EN = 1'b0;
    AUTONOMOUS_EN = 1'b0;
    DMA_EN = 1'b0;
    CLK_DIV = 8'h02;
    SMP_TICKS = 8'h01;
    AWD_HIGH = '1;
    AWD_LOW = '0;
    DATA_READ = 1'b0;
    FLAG_CLR = '0;
    FLAG_IE = 7'h02;
    repeat (16) @(posedge REF_CLK);
    RESETN <= 1'b1;
    @(negedge REF_CLK);
    check("reset flags", 16'(FLAGS), 16'h0000);
    check("reset data", DATA, DATA_RST);
    check("reset busy", 16'({CORE_POWER, BUSY, DATA_VALID}), 16'h0000);
    for (int i = 0; i < 8; i++) begin
      @(posedge REF_CLK);
      RES_SEL <= 2'(i / 2);
      ALIGN_LEFT <= i[0];
      CHAN_SEL <= chs[i];
      conv("result", fmt(lvl[chs[i]], 2'(i / 2), i[0]), 3000);
      check("wake", 16'(WAKEUP_REQ), 16'h1);
      check("end of sampling", 16'(FLAGS[FLG_EOSMP]), 16'h1);
      check("final code", 16'(CORE_DAC), fmt(lvl[chs[i]], 2'(i / 2), 1'b0) << (2 * (i / 2)));
      clr(1'b1);
      wait_idle();
    end
    @(posedge REF_CLK);
    RES_SEL <= RES_12;
    ALIGN_LEFT <= 1'b0;
    CHAN_SEL <= 5'h0D;
    start();
    repeat (20) @(negedge REF_CLK);
    check("reserved channel", 16'(BUSY), 16'h0);
    @(posedge REF_CLK);
    CHAN_SEL <= 5'h03;
    trig_test(TRIG_RISE, 1'b1);
    trig_test(TRIG_FALL, 1'b0);
    trig_test(TRIG_BOTH, 1'b0);
    CHAN_SEL <= 5'h04;
    AWD_HIGH <= {12'hFFF, 12'h7FF, 12'h800};
    AWD_LOW <= {12'h801, 12'h000, 12'h000};
    conv("window", 16'h0800, 3000);
    check("watchdogs", 16'(FLAGS[5:3]), 16'h0006);
    clr(1'b1);
    CHAN_SEL <= 5'h01;
    conv("first", fmt(lvl[1], RES_12, 1'b0), 3000);
    clr(1'b0);
    CHAN_SEL <= 5'h07;
    conv("replaced", fmt(lvl[7], RES_12, 1'b0), 3000);
    check("overrun", 16'(FLAGS[FLG_OVR]), 16'h1);
    clr(1'b1);
    WAIT_EN <= 1'b1;
    CONT_EN <= 1'b1;
    conv("cont first", fmt(lvl[7], RES_12, 1'b0), 3000);
    repeat (300) @(negedge REF_CLK);
    check("wait hold", 16'({FLAGS[FLG_OVR], BUSY, CORE_SAMPLE}), 16'h0002);
    clr(1'b1);
    wait_eoc(3000);
    check("cont again", DATA, fmt(lvl[7], RES_12, 1'b0));
    @(posedge REF_CLK);
    SW_STOP <= 1'b1;
    @(posedge REF_CLK);
    SW_STOP <= 1'b0;
    clr(1'b1);
    wait_idle();
    @(posedge REF_CLK);
    CONT_EN <= 1'b0;
    WAIT_EN <= 1'b0;
    clr(1'b1);
    SCAN_EN <= 1'b1;
    CHAN_SEL <= 5'h0D;
    for (int d = 0; d < 2; d++) begin
      DISC_EN <= d[0];
      for (int k = 0; k < 3; k++) begin
        if (d == 1 || k == 0) begin
          start();
        end
        wait_eoc(3000);
        check("scan data", DATA, fmt(lvl[sq[k]], RES_12, 1'b0));
        check("end of sequence", 16'(FLAGS[FLG_EOS]), 16'(k == 2));
        if (k < 2) begin
          check("next channel", 16'(CORE_CHANNEL), 16'(sq[k + 1]));
        end
        clr(1'b1);
      end
    end
    SCAN_EN <= 1'b0;
    DISC_EN <= 1'b0;
    CHAN_SEL <= 5'h06;
    ALIGN_LEFT <= 1'b1;
    OVS_EN <= 1'b1;
    for (int n = 0; n < 8; n += 7) begin
      OVS_RATIO <= 3'(n);
      OVS_SHIFT <= (n == 7) ? 4'h4 : 4'h0;
      conv("oversampled", 16'((20'(lvl[6]) << (n + 1)) >> ((n == 7) ? 4 : 0)), 30000);
      clr(1'b1);
    end
    OVS_EN <= 1'b0;
    ALIGN_LEFT <= 1'b0;
    ENABLE <= 1'b0;
    wait_idle();
    for (int m = 0; m < 2; m++) begin
      @(posedge REF_CLK);
      AUTO_OFF_EN <= ~m[0];
      AUTONOMOUS_EN <= m[0];
      DMA_EN <= m[0];
      repeat (10) @(negedge REF_CLK);
      check("power idle", 16'(CORE_POWER), 16'h0);
      conv("low power", fmt(lvl[6], RES_12, 1'b0), 3000);
      check("dma request", 16'(DMA_REQ), 16'(m));
      clr(1'b1);
      wait_idle();
      repeat (4) @(negedge REF_CLK);
      check("power off", 16'({CORE_POWER, DMA_REQ}), 16'h0);
    end
    end_of_test();
  end

  initial begin
    repeat (80000) @(posedge REF_CLK);
    fails++;
    $display("Error run length expected finish seen timeout");
    end_of_test();
  end
endmodule
`default_nettype wire
